// file: src/sw_pkg.sv
// Constants, types and helpers shared by both ends of the switch configuration link
package sw_pkg;

    localparam int SW_CLK_MHZ = 10;
    localparam int SW_QTR_NS = 2500;
    localparam logic [3:0] SW_ADDR_HI = 4'h9;

    localparam int SW_NREG = 8;
    localparam logic [7:0] SW_IDX_FAST_MODES = 8'h00;
    localparam logic [7:0] SW_IDX_SIDE_MODES = 8'h01;
    localparam logic [7:0] SW_IDX_RX_SET = 8'h10;
    localparam logic [7:0] SW_IDX_TERM_LO = 8'h11;
    localparam logic [7:0] SW_IDX_TERM_HI = 8'h12;
    localparam logic [7:0] SW_IDX_EQ_LO = 8'h13;
    localparam logic [7:0] SW_IDX_EQ_HI = 8'h14;
    localparam logic [7:0] SW_IDX_TX_SET = 8'h20;

    localparam int SW_S_FAST = 0;
    localparam int SW_S_SIDE = 1;
    localparam int SW_S_RX = 2;
    localparam int SW_S_TLO = 3;
    localparam int SW_S_THI = 4;
    localparam int SW_S_ELO = 5;
    localparam int SW_S_EHI = 6;
    localparam int SW_S_TX = 7;

    localparam logic [7:0] SW_REG_IDX [SW_NREG] = '{SW_IDX_FAST_MODES, SW_IDX_SIDE_MODES, SW_IDX_RX_SET,
        SW_IDX_TERM_LO, SW_IDX_TERM_HI, SW_IDX_EQ_LO, SW_IDX_EQ_HI, SW_IDX_TX_SET};
    localparam logic [7:0] SW_REG_RST [SW_NREG] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    localparam logic [7:0] SW_REG_MASK [SW_NREG] = '{8'h43, 8'h43, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
    localparam logic [SW_NREG-1:0] SW_PIN_CTRL = 8'he1;
    localparam int SW_UPD_DELAY_NS [SW_NREG] = '{1000, 1000, 1000, 1000, 1000, 1000, 1000, 1000};

    localparam int SW_EN_BIT = 6;
    localparam int SW_SEL_LSB = 0;
    localparam int SW_TERM_SEL_BIT = 0;
    localparam int SW_BOOST_LSB = 2;
    localparam int SW_OTERM_BIT = 1;
    localparam int SW_OCUR_BIT = 0;

    typedef enum logic [8:0] {
        SW_D_IDLE = 9'h001, SW_D_ADDR = 9'h002, SW_D_AACK = 9'h004, SW_D_IDX = 9'h008, SW_D_IACK = 9'h010,
        SW_D_WDAT = 9'h020, SW_D_DACK = 9'h040, SW_D_RD = 9'h080, SW_D_RACK = 9'h100
    } sw_dev_st_t;

    typedef enum logic [3:0] {
        SW_H_IDLE = 4'h1, SW_H_START = 4'h2, SW_H_BYTE = 4'h4, SW_H_STOP = 4'h8
    } sw_host_st_t;

    // Least time in ns to whole clock cycles, at least one
    function automatic int swCycles(input int ns);
        int c;
        c = (ns * SW_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : swCycles

    localparam int SW_QTR_CYC = swCycles(SW_QTR_NS);

endpackage : sw_pkg

// file: src/sw_i2c_if.sv
// Two-wire link between the switch configuration end and its master
`timescale 1ns/100ps
interface sw_i2c_if;
    logic hostSclO;
    logic hostSclOe;
    logic hostSdaO;
    logic hostSdaOe;
    logic devSdaO;
    logic devSdaOe;
    logic sclLine;
    logic sdaLine;

    // Open-drain wired AND with pull-up
    assign sclLine = !(hostSclOe && !hostSclO);
    assign sdaLine = !((hostSdaOe && !hostSdaO) || (devSdaOe && !devSdaO));

    modport dev (input sclLine, input sdaLine, output devSdaO, output devSdaOe);
    modport host (input sclLine, input sdaLine, output hostSclO, output hostSclOe, output hostSdaO, output hostSdaOe);
endinterface : sw_i2c_if

// file: src/sw_upd_window.sv
// Per-register update delay window between stored and applied value
`timescale 1ns/100ps
module sw_upd_window #(
    parameter int DELAY_CYC = 10,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register side
    input wire logic wrStb,
    input wire logic [7:0] wrData,
    input wire logic [7:0] curVal,
    // Physical side
    output logic [7:0] applied_r
);
    localparam int CW = $clog2(DELAY_CYC + 1);
    localparam logic [CW-1:0] DLY = CW'(DELAY_CYC);
    logic [CW-1:0] cnt_r;

    if (DELAY_CYC < 1) begin : g_bad_delay
        $error("sw_upd_window: DELAY_CYC must be at least 1");
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            applied_r <= RST_VAL;
        end else if (cnt_r == '0) begin
            if (wrStb) begin
                applied_r <= wrData;
                cnt_r <= DLY;
            end
        end else begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == CW'(1)) begin
                // A write in the closing cycle is the latest value
                applied_r <= wrStb ? wrData : curVal;
            end
        end
    end
endmodule : sw_upd_window

// file: src/sw_dev_end.sv
// Switch configuration end: two-wire slave, register bank, pin control, update windows
`timescale 1ns/100ps
module sw_dev_end (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Two-wire link
    sw_i2c_if.dev bus,
    // Address select pins
    input wire logic slaveAddrSelBit2,
    input wire logic slaveAddrSelBit1,
    input wire logic slaveAddrSelBit0,
    // Parallel control pins
    input wire logic pinPathEnable,
    input wire logic [1:0] pinSourceSelect,
    input wire logic pinEqualizerLevel,
    input wire logic [1:0] pinBoostLevel,
    input wire logic pinOutputTermination,
    input wire logic pinOutputCurrent,
    // Applied configuration
    output logic fastPathEnable,
    output logic [1:0] fastSourceSelect,
    output logic sidePathEnable,
    output logic [1:0] sideSourceSelect,
    output logic [15:0] channelTerminationConnect,
    output logic [15:0] channelEqualizerLevel,
    output logic [1:0] outputBoostLevel,
    output logic outputTerminationOn,
    output logic outputCurrentLevel,
    output logic pinControlActive
);
    import sw_pkg::*;

    localparam int NSYNC = 13;

    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [1:0] pinLive_r;
    logic sclPrev_r;
    logic sdaPrev_r;
    logic scl;
    logic sda;
    logic [2:0] addrSel;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    sw_dev_st_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] txShift_r;
    logic [7:0] index_r;
    logic isRead_r;
    logic sdaOe_r;
    logic parMode_r;
    logic [15:0] termConn_r;
    logic serWr;
    logic idxValid;
    logic [2:0] idxSlot;
    logic [7:0] rdByte;
    logic [7:0] regs_r [SW_NREG];
    logic [7:0] applied [SW_NREG];
    logic [7:0] pinImg [SW_NREG];

    assign pinRaw = {slaveAddrSelBit2, slaveAddrSelBit1, slaveAddrSelBit0, pinPathEnable, pinSourceSelect,
        pinEqualizerLevel, pinBoostLevel, pinOutputTermination, pinOutputCurrent, bus.sclLine, bus.sdaLine};

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= {{(NSYNC-2){1'b0}}, 2'h3};
            sync2_r <= {{(NSYNC-2){1'b0}}, 2'h3};
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
            pinLive_r <= 2'h0;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            pinLive_r <= {pinLive_r[0], 1'b1};
            sclPrev_r <= sync2_r[1];
            sdaPrev_r <= sync2_r[0];
        end
    end

    assign scl = sync2_r[1];
    assign sda = sync2_r[0];
    assign addrSel = sync2_r[12:10];
    assign sclRise = scl && !sclPrev_r;
    assign sclFall = !scl && sclPrev_r;
    assign startDet = scl && sclPrev_r && sdaPrev_r && !sda;
    assign stopDet = scl && sclPrev_r && !sdaPrev_r && sda;

    // Index to register slot
    always_comb begin
        idxValid = 1'b0;
        idxSlot = 3'h0;
        for (int i = 0; i < SW_NREG; i++) begin
            if (index_r == SW_REG_IDX[i]) begin
                idxValid = 1'b1;
                idxSlot = 3'(i);
            end
        end
    end

    assign rdByte = idxValid ? regs_r[idxSlot] : 8'h00;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= SW_D_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            txShift_r <= 8'h00;
            index_r <= 8'h00;
            isRead_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end else if (startDet) begin
            st_r <= SW_D_ADDR;
            cnt_r <= 4'h0;
            sdaOe_r <= 1'b0;
        end else if (stopDet) begin
            st_r <= SW_D_IDLE;
            sdaOe_r <= 1'b0;
        end else begin
            unique case (st_r)
                SW_D_IDLE: begin
                end
                SW_D_ADDR, SW_D_IDX, SW_D_WDAT: begin
                    if (sclRise) begin
                        shift_r <= {shift_r[6:0], sda};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (sclFall && cnt_r == 4'h8) begin
                        sdaOe_r <= 1'b1;
                        if (st_r == SW_D_ADDR) begin
                            if (shift_r[7:1] == {SW_ADDR_HI, addrSel}) begin
                                isRead_r <= shift_r[0];
                                st_r <= SW_D_AACK;
                            end else begin
                                sdaOe_r <= 1'b0;
                                st_r <= SW_D_IDLE;
                            end
                        end else if (st_r == SW_D_IDX) begin
                            index_r <= shift_r;
                            st_r <= SW_D_IACK;
                        end else begin
                            st_r <= SW_D_DACK;
                        end
                    end
                end
                SW_D_AACK: begin
                    if (sclFall) begin
                        cnt_r <= 4'h0;
                        if (isRead_r) begin
                            txShift_r <= rdByte;
                            sdaOe_r <= !rdByte[7];
                            st_r <= SW_D_RD;
                        end else begin
                            sdaOe_r <= 1'b0;
                            st_r <= SW_D_IDX;
                        end
                    end
                end
                SW_D_IACK: begin
                    if (sclFall) begin
                        cnt_r <= 4'h0;
                        sdaOe_r <= 1'b0;
                        st_r <= SW_D_WDAT;
                    end
                end
                SW_D_DACK, SW_D_RACK: begin
                    if (sclFall) begin
                        sdaOe_r <= 1'b0;
                        st_r <= SW_D_IDLE;
                    end
                end
                SW_D_RD: begin
                    if (sclFall) begin
                        if (cnt_r == 4'h7) begin
                            sdaOe_r <= 1'b0;
                            st_r <= SW_D_RACK;
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                            txShift_r <= {txShift_r[6:0], 1'b0};
                            sdaOe_r <= !txShift_r[6];
                        end
                    end
                end
            endcase
        end
    end

    // Store on the falling clock of the last data bit
    assign serWr = (st_r == SW_D_WDAT) && sclFall && cnt_r == 4'h8 && !startDet && !stopDet;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            parMode_r <= 1'b1;
        end else if (st_r == SW_D_ADDR && sclFall && cnt_r == 4'h8 && !startDet && !stopDet
                     && shift_r[7:1] == {SW_ADDR_HI, addrSel}) begin
            parMode_r <= 1'b0;
        end
    end

    // Pin images of pin-controlled registers
    always_comb begin
        for (int i = 0; i < SW_NREG; i++) begin
            pinImg[i] = regs_r[i];
        end
        pinImg[SW_S_FAST] = 8'h00;
        pinImg[SW_S_FAST][SW_EN_BIT] = sync2_r[9];
        pinImg[SW_S_FAST][SW_SEL_LSB +: 2] = sync2_r[8:7];
        pinImg[SW_S_ELO] = {8{sync2_r[6]}};
        pinImg[SW_S_EHI] = {8{sync2_r[6]}};
        pinImg[SW_S_TX] = 8'h00;
        pinImg[SW_S_TX][SW_BOOST_LSB +: 2] = sync2_r[5:4];
        pinImg[SW_S_TX][SW_OTERM_BIT] = sync2_r[3];
        pinImg[SW_S_TX][SW_OCUR_BIT] = sync2_r[2];
    end

    for (genvar s = 0; s < SW_NREG; s++) begin : g_reg
        logic serHit;
        logic pinHit;
        logic wrStb;
        logic [7:0] wrData;

        assign serHit = serWr && idxValid && idxSlot == 3'(s);
        // Pin images wait until the synchroniser holds real levels
        assign pinHit = parMode_r && pinLive_r[1] && SW_PIN_CTRL[s] && pinImg[s] != regs_r[s];
        assign wrStb = serHit || pinHit;
        assign wrData = serHit ? (shift_r & SW_REG_MASK[s]) : pinImg[s];

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                regs_r[s] <= SW_REG_RST[s];
            end else if (wrStb) begin
                regs_r[s] <= wrData;
            end
        end

        sw_upd_window #(
            .DELAY_CYC(swCycles(SW_UPD_DELAY_NS[s])),
            .RST_VAL(SW_REG_RST[s])
        ) u_win (
            .ref_clk(ref_clk),
            .rst(rst),
            .wrStb(wrStb),
            .wrData(wrData),
            .curVal(regs_r[s]),
            .applied_r(applied[s])
        );
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            termConn_r <= 16'h0000;
        end else if (applied[SW_S_RX][SW_TERM_SEL_BIT]) begin
            termConn_r <= {applied[SW_S_THI], applied[SW_S_TLO]};
        end else begin
            termConn_r <= 16'h0000;
        end
    end

    assign bus.devSdaO = 1'b0;
    assign bus.devSdaOe = sdaOe_r;
    assign fastPathEnable = applied[SW_S_FAST][SW_EN_BIT];
    assign fastSourceSelect = applied[SW_S_FAST][SW_SEL_LSB +: 2];
    assign sidePathEnable = applied[SW_S_SIDE][SW_EN_BIT];
    assign sideSourceSelect = applied[SW_S_SIDE][SW_SEL_LSB +: 2];
    assign channelTerminationConnect = termConn_r;
    assign channelEqualizerLevel = {applied[SW_S_EHI], applied[SW_S_ELO]};
    assign outputBoostLevel = applied[SW_S_TX][SW_BOOST_LSB +: 2];
    assign outputTerminationOn = applied[SW_S_TX][SW_OTERM_BIT];
    assign outputCurrentLevel = applied[SW_S_TX][SW_OCUR_BIT];
    assign pinControlActive = parMode_r;
endmodule : sw_dev_end

// file: src/sw_host_end.sv
// Two-wire master end: single register write or read per command
`timescale 1ns/100ps
module sw_host_end (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Two-wire link
    sw_i2c_if.host bus,
    // Command
    input wire logic cmdValid,
    input wire logic cmdRead,
    input wire logic [7:0] cmdIndex,
    input wire logic [7:0] cmdData,
    input wire logic [2:0] addrSel,
    output logic cmdReady_r,
    // Response
    output logic rspValid_r,
    output logic [7:0] rspData_r,
    output logic rspNack_r
);
    import sw_pkg::*;

    localparam logic [15:0] QTR = 16'(SW_QTR_CYC - 1);

    sw_host_st_t st_r;
    logic sda1_r;
    logic sda2_r;
    logic [15:0] div_r;
    logic tick;
    logic [1:0] q_r;
    logic [2:0] seq_r;
    logic [3:0] bit_r;
    logic isRead_r;
    logic nack_r;
    logic [7:0] index_r;
    logic [7:0] data_r;
    logic [2:0] addr_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic sclOe_r;
    logic sdaOe_r;
    logic rxByte;
    logic [2:0] seqNext;
    logic [2:0] stopSeq;
    logic [7:0] nextByte;
    sw_host_st_t nextSt;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda1_r <= 1'b1;
            sda2_r <= 1'b1;
        end else begin
            sda1_r <= bus.sdaLine;
            sda2_r <= sda1_r;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= 16'h0000;
        end else if (st_r == SW_H_IDLE || div_r == 16'h0000) begin
            div_r <= QTR;
        end else begin
            div_r <= div_r - 16'h0001;
        end
    end

    assign tick = st_r != SW_H_IDLE && div_r == 16'h0000;
    assign rxByte = isRead_r && seq_r == 3'h5;
    assign stopSeq = isRead_r ? 3'h6 : 3'h4;
    assign seqNext = nack_r ? stopSeq : seq_r + 3'h1;

    // Element that follows the current one
    always_comb begin
        if (seqNext == stopSeq) begin
            nextSt = SW_H_STOP;
        end else if (isRead_r && seqNext == 3'h3) begin
            nextSt = SW_H_START;
        end else begin
            nextSt = SW_H_BYTE;
        end
        unique case (seqNext)
            3'h1: nextByte = {SW_ADDR_HI, addr_r, 1'b0};
            3'h2: nextByte = index_r;
            3'h3: nextByte = data_r;
            3'h4: nextByte = {SW_ADDR_HI, addr_r, 1'b1};
            default: nextByte = 8'hff;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= SW_H_IDLE;
            q_r <= 2'h0;
            seq_r <= 3'h0;
            bit_r <= 4'h0;
            isRead_r <= 1'b0;
            nack_r <= 1'b0;
            index_r <= 8'h00;
            data_r <= 8'h00;
            addr_r <= 3'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            sclOe_r <= 1'b0;
            sdaOe_r <= 1'b0;
            cmdReady_r <= 1'b0;
            rspValid_r <= 1'b0;
            rspData_r <= 8'h00;
            rspNack_r <= 1'b0;
        end else begin
            rspValid_r <= 1'b0;
            unique case (st_r)
                SW_H_IDLE: begin
                    cmdReady_r <= 1'b1;
                    if (cmdValid && cmdReady_r) begin
                        cmdReady_r <= 1'b0;
                        isRead_r <= cmdRead;
                        index_r <= cmdIndex;
                        data_r <= cmdData;
                        addr_r <= addrSel;
                        nack_r <= 1'b0;
                        seq_r <= 3'h0;
                        q_r <= 2'h0;
                        st_r <= SW_H_START;
                    end
                end
                SW_H_START, SW_H_STOP: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        unique case (q_r)
                            2'h0: sdaOe_r <= (st_r == SW_H_STOP);
                            2'h1: sclOe_r <= 1'b0;
                            2'h2: sdaOe_r <= (st_r == SW_H_START);
                            2'h3: begin
                                if (st_r == SW_H_START) begin
                                    sclOe_r <= 1'b1;
                                    seq_r <= seqNext;
                                    tx_r <= nextByte;
                                    bit_r <= 4'h0;
                                    st_r <= nextSt;
                                end else begin
                                    rspValid_r <= 1'b1;
                                    rspNack_r <= nack_r;
                                    st_r <= SW_H_IDLE;
                                end
                            end
                        endcase
                    end
                end
                SW_H_BYTE: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        unique case (q_r)
                            2'h0: begin
                                if (bit_r != 4'h8) begin
                                    sdaOe_r <= !rxByte && !tx_r[7];
                                end else begin
                                    sdaOe_r <= rxByte;
                                end
                            end
                            2'h1: sclOe_r <= 1'b0;
                            2'h2: begin
                                if (bit_r != 4'h8) begin
                                    rx_r <= {rx_r[6:0], sda2_r};
                                end else if (!rxByte && sda2_r) begin
                                    nack_r <= 1'b1;
                                end
                            end
                            2'h3: begin
                                sclOe_r <= 1'b1;
                                if (bit_r == 4'h8) begin
                                    if (rxByte) begin
                                        rspData_r <= rx_r;
                                    end
                                    seq_r <= seqNext;
                                    tx_r <= nextByte;
                                    bit_r <= 4'h0;
                                    st_r <= nextSt;
                                end else begin
                                    bit_r <= bit_r + 4'h1;
                                    tx_r <= {tx_r[6:0], 1'b1};
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    assign bus.hostSclO = 1'b0;
    assign bus.hostSclOe = sclOe_r;
    assign bus.hostSdaO = 1'b0;
    assign bus.hostSdaOe = sdaOe_r;
endmodule : sw_host_end

// file: dv/sw_cfg_props.sv
// Checks on the two-wire link between both ends
`timescale 1ns/100ps
module sw_cfg_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link signals
    input wire logic hostSclOe,
    input wire logic hostSdaOe,
    input wire logic devSdaOe,
    input wire logic sclLine,
    input wire logic sdaLine
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence startCond;
        $fell(sdaLine) && sclLine;
    endsequence
    sequence stopCond;
        $rose(sdaLine) && sclLine;
    endsequence
    dev_stable_a: assert property (sclLine && $past(sclLine) |-> $stable(devSdaOe))
        else $error("device data moved while clock high");
    ack_delay_a: assert property ($rose(devSdaOe) |-> !sclLine && !$past(sclLine, 2))
        else $error("device drive too soon after clock fall");
    dev_release_a: assert property (devSdaOe |-> ##[1:1000] !devSdaOe)
        else $error("device holds data line too long");
    scl_low_a: assert property ($fell(sclLine) |=> (!sclLine && hostSclOe) [*8])
        else $error("clock low phase too short");
    start_hold_a: assert property (startCond |=> sclLine [*8])
        else $error("clock not held after start");
    stop_idle_a: assert property (stopCond |=> (sdaLine && sclLine) [*8])
        else $error("bus not idle after stop");
    reset_quiet_a: assert property ($fell(rst) |-> !devSdaOe [*3])
        else $error("device drives right after reset");
    no_clash_a: assert property (devSdaOe && sclLine |-> !hostSdaOe)
        else $error("both ends drive data line");
endmodule : sw_cfg_props

// file: dv/test_switch_config_serial_parallel_ctrl.sv
// Testbench joining both ends of the switch configuration link
`timescale 1ns/100ps
module test_switch_config_serial_parallel_ctrl;
    import sw_pkg::*;
    logic ref_clk = 0, rst = 1, cmdValid = 0, cmdRead = 0, pinPathEnable = 0, pinEqualizerLevel = 0;
    logic [7:0] cmdIndex = 8'h00, cmdData = 8'h00, rspData_r, regVal [SW_NREG];
    logic [2:0] addrSel = 3'h0, devAddr = 3'h0;
    logic [1:0] pinSourceSelect = 2'h0, s, fastSourceSelect, sideSourceSelect, outputBoostLevel;
    logic [3:0] pinTx = 4'h0;
    logic cmdReady_r, rspValid_r, rspNack_r, pinControlActive, fastPathEnable;
    logic sidePathEnable, outputTerminationOn, outputCurrentLevel;
    logic [15:0] channelTerminationConnect, channelEqualizerLevel;
    logic [9:0] expQ [$];
    logic [9:0] note;
    int failures = 0, n_compared = 0;
    always #50 ref_clk = ~ref_clk;
    sw_i2c_if sw_i2c_if_inst ();
    sw_dev_end sw_dev_end_inst (.ref_clk, .rst, .bus(sw_i2c_if_inst.dev), .slaveAddrSelBit2(devAddr[2]),
        .slaveAddrSelBit1(devAddr[1]), .slaveAddrSelBit0(devAddr[0]), .pinPathEnable, .pinSourceSelect,
        .pinEqualizerLevel, .pinBoostLevel(pinTx[3:2]), .pinOutputTermination(pinTx[1]), .pinOutputCurrent(pinTx[0]),
        .fastPathEnable, .fastSourceSelect, .sidePathEnable, .sideSourceSelect, .channelTerminationConnect,
        .channelEqualizerLevel, .outputBoostLevel, .outputTerminationOn, .outputCurrentLevel, .pinControlActive);
    sw_host_end sw_host_end_inst (.ref_clk, .rst, .bus(sw_i2c_if_inst.host), .cmdValid, .cmdRead, .cmdIndex,
        .cmdData, .addrSel, .cmdReady_r, .rspValid_r, .rspData_r, .rspNack_r);
    sw_cfg_props sw_cfg_props_inst (.ref_clk, .rst, .hostSclOe(sw_i2c_if_inst.hostSclOe),
        .hostSdaOe(sw_i2c_if_inst.hostSdaOe), .devSdaOe(sw_i2c_if_inst.devSdaOe),
        .sclLine(sw_i2c_if_inst.sclLine), .sdaLine(sw_i2c_if_inst.sdaLine));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d, input logic [2:0] as,
        input logic [9:0] e);
        do @(negedge ref_clk); while (cmdReady_r !== 1'b1);
        @(posedge ref_clk);
        {cmdValid, cmdRead, cmdIndex, cmdData, addrSel} <= {1'b1, rd, idx, d, as};
        expQ.push_back(e);
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        do @(negedge ref_clk); while (cmdReady_r !== 1'b1);
    endtask : xfer
    task automatic final_report;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    always @(negedge ref_clk) begin
        if (rspValid_r === 1'b1) begin
            note = expQ.pop_front();
            chk("nack", note[8], rspNack_r);
            if (note[9]) chk("rdata", note[7:0], rspData_r);
        end
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        final_report;
    end
    initial begin
        void'($urandom(43127));
        {devAddr, pinPathEnable, pinSourceSelect, pinEqualizerLevel, pinTx} <= 11'($urandom);
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (20) @(negedge ref_clk);
        chk("pinMode", 1'b1, pinControlActive);
        chk("fastSel", pinSourceSelect, fastSourceSelect);
        chk("fastEn", pinPathEnable, fastPathEnable);
        chk("eq", {16{pinEqualizerLevel}}, channelEqualizerLevel);
        chk("term", 16'h0, channelTerminationConnect);
        chk("tx", pinTx, {outputBoostLevel, outputTerminationOn, outputCurrentLevel});
        chk("side", 3'h4, {sidePathEnable, sideSourceSelect});
        $display("test reset done");
        s = pinSourceSelect + 2'h1;
        @(posedge ref_clk) pinSourceSelect <= s;
        repeat (4) @(posedge ref_clk);
        pinSourceSelect <= s + 2'h1;
        repeat (5) @(negedge ref_clk);
        chk("fastSel", s, fastSourceSelect);
        repeat (6) @(negedge ref_clk);
        chk("fastSel", s + 2'h1, fastSourceSelect);
        $display("test window done");
        xfer(1'b0, 8'h00, 8'h00, devAddr ^ 3'h5, 10'h100);
        chk("pinMode", 1'b1, pinControlActive);
        $display("test address done");
        for (int i = 0; i < SW_NREG; i++) begin
            regVal[i] = 8'($urandom) | ((i == SW_S_RX) ? 8'h01 : 8'h00);
            xfer(1'b0, SW_REG_IDX[i], regVal[i], devAddr, 10'h000);
            xfer(1'b1, SW_REG_IDX[i], 8'h00, devAddr, {2'b10, regVal[i] & SW_REG_MASK[i]});
        end
        @(posedge ref_clk) pinSourceSelect <= ~regVal[0][1:0];
        repeat (30) @(negedge ref_clk);
        chk("pinMode", 1'b0, pinControlActive);
        chk("fastSel", regVal[0][1:0], fastSourceSelect);
        chk("term", regVal[2][0] ? {regVal[4], regVal[3]} : 16'h0, channelTerminationConnect);
        chk("side", {regVal[1][6], regVal[1][1:0]}, {sidePathEnable, sideSourceSelect});
        chk("tx", regVal[7][3:0], {outputBoostLevel, outputTerminationOn, outputCurrentLevel});
        xfer(1'b0, SW_IDX_RX_SET, 8'h00, devAddr, 10'h000);
        repeat (5) @(negedge ref_clk);
        chk("term", 16'h0, channelTerminationConnect);
        $display("test registers done");
        s = regVal[0][1:0] ^ 2'h2;
        @(posedge ref_clk) pinSourceSelect <= s;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(negedge ref_clk);
        chk("pinMode", 1'b1, pinControlActive);
        chk("fastSel", s, fastSourceSelect);
        chk("term", 16'h0, channelTerminationConnect);
        $display("test second reset done");
        final_report;
    end
endmodule : test_switch_config_serial_parallel_ctrl
